// File: verilog/eep_slave.sv
/*
  Two-wire serial memory slave: 32K x 8 array, 64-byte page writes with
  roll-over, self-timed write cycle with ack polling, write protect,
  current-address, random and sequential reads.
  Assumes scl, sda, wp and select pins are asynchronous to clk (20 MHz),
  bus clock well below clk/8; sda resolved by an external pull-up.
*/
// Function
// - array split into aligned 64-byte pages
// - page write wraps within same page
// - page write may start mid-page
// - ack each write byte, advance address
// - over 64 bytes overwrite buffered bytes
// - stop after write starts internal cycle
// - ignore bus while write cycle busy
// - no address ack while busy
// - write protect refuses first data byte
// - refused write starts no programming
// - direction bit one means read
// - counter holds last address plus one
// - current read: ack, byte, release
// - master ack fetches next sequential byte
// - read ends on nack or stop
// - read counter wraps whole array
// - match 4-bit device type field
// - match 3-bit select field to pins
// - use 7 plus 8 word address bits
`timescale 1ns/1ps

`include "eep_consts.svh"

module eep_slave
  import eep_pkg::*;
#(
  parameter int TWR_CYCLES = `EEP_TWR_CYC
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire eep_pkg::eep_bus_in_t bus_i,
  input  wire logic                write_protect,
  input  wire logic [2:0]          device_select_pins,
  output eep_pkg::eep_bus_out_t    bus_o,
  output logic                     write_busy
);
  import eep_pkg::*;

  initial begin
    if (TWR_CYCLES < 1) $error("TWR_CYCLES must be at least one");
  end

  localparam int AW = `EEP_ADDR_W;
  localparam int PW = `EEP_PAGE_BITS;

  // two-flop synchronisers, first stage read only by second
  logic [3:0] s1_q, s2_q;
  logic       scl_q, sda_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q  <= 4'hF;
      s2_q  <= 4'hF;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      s1_q  <= {write_protect, bus_i.scl, bus_i.sda, 1'b0};
      s2_q  <= s1_q;
      scl_q <= s2_q[2];
      sda_q <= s2_q[1];
    end
  end
  logic scl_s, sda_s, wp_s;
  assign wp_s  = s2_q[3];
  assign scl_s = s2_q[2];
  assign sda_s = s2_q[1];

  logic [2:0] sel1_q, sel_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel1_q <= 3'h0;
      sel_q  <= 3'h0;
    end else begin
      sel1_q <= device_select_pins;
      sel_q  <= sel1_q;
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;

  logic [7:0]    mem [0:(1<<AW)-1];
  logic [7:0]    page_buf [0:`EEP_PAGE_BYTES-1];
  logic [`EEP_PAGE_BYTES-1:0] page_vld_q;

  eep_state_t    st_q, ret_q;
  logic [3:0]    bit_q;
  logic [7:0]    sh_q, tx_q;
  logic [AW-1:0] addr_q, page_base_q;
  logic [6:0]    hi_q;
  logic          rd_q, ack_drive_q, wr_pend_q, refused_q;
  logic          sda_o_q, sda_oe_q;
  logic [31:0]   twr_q;
  logic          prog_go;

  // bus idle or ignored while busy
  logic busy_q;
  assign write_busy = busy_q;

  // programming timer; written bytes of the page are copied into the array at expiry
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_q <= 1'b0;
      twr_q  <= 32'h0;
    end else if (prog_go) begin
      busy_q <= 1'b1;
      twr_q  <= 32'(TWR_CYCLES - 1);
    end else if (busy_q) begin
      if (twr_q == 32'h0) busy_q <= 1'b0;
      else twr_q <= twr_q - 32'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (busy_q && twr_q == 32'h0) begin
      for (int i = 0; i < `EEP_PAGE_BYTES; i++) begin
        if (page_vld_q[i]) mem[{page_base_q[AW-1:PW], PW'(i)}] <= page_buf[i];
      end
    end
  end

  assign prog_go = stop_c & wr_pend_q & ~refused_q & ~busy_q;

  // busy length counter, only read by the length check
  logic [31:0] busy_cnt_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_cnt_q <= 32'h0;
    end else if (prog_go) begin
      busy_cnt_q <= 32'h0;
    end else if (busy_q) begin
      busy_cnt_q <= busy_cnt_q + 32'h1;
    end
  end

  logic [7:0] rx_byte;
  assign rx_byte = {sh_q[6:0], sda_s};

  // main protocol sequencer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q        <= ST_IDLE;
      ret_q       <= ST_IDLE;
      bit_q       <= 4'h0;
      sh_q        <= 8'h00;
      tx_q        <= 8'h00;
      addr_q      <= '0;
      page_base_q <= '0;
      hi_q        <= 7'h00;
      rd_q        <= 1'b0;
      ack_drive_q <= 1'b0;
      wr_pend_q   <= 1'b0;
      refused_q   <= 1'b0;
      page_vld_q  <= '0;
      sda_o_q     <= 1'b1;
      sda_oe_q    <= 1'b0;
    end else if (busy_q) begin
      st_q     <= ST_IDLE;
      sda_oe_q <= 1'b0;
      wr_pend_q <= 1'b0;
    end else if (stop_c) begin
      st_q      <= ST_IDLE;
      sda_oe_q  <= 1'b0;
      wr_pend_q <= 1'b0;
      refused_q <= 1'b0;
    end else if (start_c) begin
      st_q      <= ST_DEVADDR;
      bit_q     <= 4'h0;
      sda_oe_q  <= 1'b0;
      wr_pend_q <= 1'b0;
      refused_q <= 1'b0;
      page_vld_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE, ST_IGNORE: sda_oe_q <= 1'b0;
        ST_DEVADDR, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA: begin
          if (scl_rise) begin
            sh_q  <= rx_byte;
            bit_q <= bit_q + 4'h1;
          end
          if (scl_fall && bit_q == `EEP_BIT_ACK) begin
            bit_q <= 4'h0;
            sda_o_q <= 1'b0;
            unique case (st_q)
              ST_DEVADDR: begin
                if (sh_q[7:4] == `EEP_DEV_TYPE && sh_q[3:1] == sel_q) begin
                  rd_q     <= sh_q[0];
                  sda_oe_q <= 1'b1;
                  tx_q     <= mem[addr_q];
                  ret_q    <= sh_q[0] ? ST_RDATA : ST_ADDR_HI;
                  st_q     <= ST_ACK;
                end else begin
                  st_q <= ST_IGNORE;
                end
              end
              ST_ADDR_HI: begin
                hi_q     <= sh_q[6:0];
                sda_oe_q <= 1'b1;
                ret_q    <= ST_ADDR_LO;
                st_q     <= ST_ACK;
              end
              ST_ADDR_LO: begin
                addr_q      <= {hi_q, sh_q};
                page_base_q <= {hi_q, sh_q};
                sda_oe_q    <= 1'b1;
                ret_q       <= ST_WDATA;
                st_q        <= ST_ACK;
              end
              default: begin
                if (wp_s) begin
                  refused_q <= 1'b1;
                  st_q      <= ST_IGNORE;
                end else begin
                  page_buf[addr_q[PW-1:0]]   <= sh_q;
                  page_vld_q[addr_q[PW-1:0]] <= 1'b1;
                  wr_pend_q  <= 1'b1;
                  // wrap inside the page only
                  addr_q     <= {addr_q[AW-1:PW], PW'(addr_q[PW-1:0] + 1'b1)};
                  sda_oe_q   <= 1'b1;
                  ret_q      <= ST_WDATA;
                  st_q       <= ST_ACK;
                end
              end
            endcase
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            sda_oe_q <= 1'b0;
            bit_q    <= 4'h0;
            st_q     <= ret_q;
            if (ret_q == ST_RDATA) begin
              sda_oe_q <= ~tx_q[7];
              sda_o_q  <= 1'b0;
              addr_q   <= addr_q + 1'b1;
            end
          end
        end
        ST_RDATA: begin
          if (scl_fall) begin
            if (bit_q == `EEP_BIT_LAST) begin
              sda_oe_q <= 1'b0;
              st_q     <= ST_RACK;
            end else begin
              tx_q     <= {tx_q[6:0], 1'b0};
              sda_oe_q <= ~tx_q[6];
              bit_q    <= bit_q + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              st_q <= ST_IGNORE;
            end else begin
              tx_q <= mem[addr_q];
              ret_q <= ST_RDATA;
              st_q <= ST_ACK;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_o <= '{sda_o: 1'b1, sda_oe: 1'b0};
    end else begin
      bus_o <= '{sda_o: 1'b0, sda_oe: sda_oe_q};
    end
  end

  a_busy_no_drive: assert property (@(posedge clk) disable iff (sys_rst)
    busy_q |=> !sda_oe_q) else $error("drove sda while busy");
  a_prog_starts: assert property (@(posedge clk) disable iff (sys_rst)
    prog_go |=> busy_q) else $error("write cycle did not start");
  a_refuse_no_prog: assert property (@(posedge clk) disable iff (sys_rst)
    refused_q |-> !prog_go) else $error("refused write programmed");
  a_page_wrap: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == ST_WDATA && scl_fall && bit_q == `EEP_BIT_ACK && !wp_s && !busy_q && !start_c && !stop_c)
      |=> (addr_q[AW-1:PW] == $past(addr_q[AW-1:PW]))
          && (addr_q[PW-1:0] == PW'($past(addr_q[PW-1:0]) + 1'b1))) else $error("page crossed");
  a_busy_len: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(busy_q) |-> busy_cnt_q == 32'(TWR_CYCLES)) else $error("write cycle wrong length");
  a_wp_no_ack: assert property (@(posedge clk) disable iff (sys_rst)
    refused_q |-> !(st_q == ST_ACK && ret_q == ST_WDATA)) else $error("acked protected data");
  a_read_nack_end: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == ST_RACK && scl_rise && sda_s && !stop_c && !start_c && !busy_q) |=> st_q == ST_IGNORE)
    else $error("read did not end on nack");
  a_read_incr: assert property (@(posedge clk) disable iff (sys_rst)
    (st_q == ST_ACK && ret_q == ST_RDATA && scl_fall && !busy_q && !stop_c && !start_c)
      |=> addr_q == $past(addr_q) + 1'b1) else $error("read counter not advanced");

endmodule

// File: verilog/eep_consts.svh
/*
  Constants for the two-wire serial memory slave: slave address fields,
  address widths, page geometry, bus bit count and write-cycle time.
  Assumes it is included by bare name from the package and design files.
*/
`ifndef EEP_CONSTS_SVH
`define EEP_CONSTS_SVH

// device-type code is arbitrary here; a product sets its own
`define EEP_DEV_TYPE     4'h6
`define EEP_ADDR_W       15
`define EEP_PAGE_BYTES   64
`define EEP_PAGE_BITS    6
`define EEP_BIT_LAST     4'h7
`define EEP_BIT_ACK      4'h8
`define EEP_CLK_HZ       20000000
`define EEP_TWR_US       6000
`define EEP_TWR_CYC      ((`EEP_TWR_US * (`EEP_CLK_HZ / 1000000)))

`endif

// File: verilog/eep_pkg.sv
/*
  Types for the two-wire serial memory slave.
  Assumes eep_consts.svh is on the include path.
*/
`include "eep_consts.svh"

package eep_pkg;

  // two-wire pin group as seen at the device
  typedef struct packed {
    logic scl;
    logic sda;
  } eep_bus_in_t;

  typedef struct packed {
    logic sda_o;
    logic sda_oe;
  } eep_bus_out_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WDATA,
    ST_RDATA,
    ST_RACK,
    ST_ACK,
    ST_IGNORE
  } eep_state_t;

endpackage

// File: tb/eep_master.sv
/*
  Two-wire bus master model: start, stop, byte write and byte read.
  Assumes the bench resolves sda as a pulled-up wire from all enables.
*/
`timescale 1ns/1ps

module eep_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // also serves as repeated start, so no stop is needed before it
  task automatic start();
    sda_low <= 1'b0;
    wt(4);
    scl <= 1'b1;
    wt(8);
    sda_low <= 1'b1;
    wt(8);
    scl <= 1'b0;
  endtask

  // scl then stands high until the next frame
  task automatic stop();
    sda_low <= 1'b1;
    wt(4);
    scl <= 1'b1;
    wt(8);
    sda_low <= 1'b0;
    wt(8);
  endtask

  // 8 clk per scl phase keeps the slave's synchroniser comfortable
  task automatic bitx(input logic b, output logic smp);
    sda_low <= ~b;
    wt(4);
    scl <= 1'b1;
    wt(4);
    smp = sda;
    wt(4);
    scl <= 1'b0;
    wt(4);
  endtask

  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic smp;
    for (int i = 7; i >= 0; i--) begin
      bitx(v[i], smp);
    end
    bitx(1'b1, smp);
    ack = ~smp;
  endtask

  task automatic rbyte(input logic ack, output logic [7:0] v);
    logic smp;
    for (int i = 0; i < 8; i++) begin
      bitx(1'b1, smp);
      v = {v[6:0], smp};
    end
    bitx(~ack, smp);
  endtask
endmodule

// File: tb/eep_slave_bench.sv
/*
  Self-checking bench for eep_slave: page writes, polling, protection, reads.
  Assumes eep_master drives scl and the master side of sda.
*/
`timescale 1ns/1ps

module eep_slave_bench;
  import eep_pkg::*;
  localparam int TWR = 400;
  logic         clk;
  logic         sys_rst;
  logic         write_protect;
  logic [2:0]   device_select_pins;
  eep_bus_in_t  bus_i;
  eep_bus_out_t bus_o;
  logic         write_busy;
  logic         scl;
  logic         sda_low;
  logic         ack;
  logic [7:0]   d;
  int           fail_count;
  int           comparisons;

  assign bus_i = '{scl: scl, sda: ~(sda_low | bus_o.sda_oe)};

  eep_slave #(.TWR_CYCLES(TWR)) dut (
    .clk(clk), .sys_rst(sys_rst), .bus_i(bus_i), .write_protect(write_protect),
    .device_select_pins(device_select_pins), .bus_o(bus_o), .write_busy(write_busy));
  eep_master m (.clk(clk), .sda(bus_i.sda), .scl(scl), .sda_low(sda_low));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic results();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ak(input logic e);
    chk({7'h00, ack}, {7'h00, e});
  endtask

  task automatic bad(input logic [7:0] sa);
    m.start();
    m.wbyte(sa, ack);
    ak(1'b0);
    m.stop();
  endtask

  task automatic addr(input logic [15:0] wa);
    m.start();
    m.wbyte(8'h6A, ack);
    ak(1'b1);
    m.wbyte(wa[15:8], ack);
    ak(1'b1);
    m.wbyte(wa[7:0], ack);
    ak(1'b1);
  endtask

  // first poll lands well inside the busy time, so it must be refused
  task automatic finish_write();
    int k;
    k = 0;
    while (write_busy !== 1'b1 && k < 10) begin
      @(posedge clk);
      k++;
    end
    chk({7'h00, write_busy}, 8'h01);
    m.start();
    m.wbyte(8'h6A, ack);
    ak(1'b0);
    k = 0;
    while (ack !== 1'b1 && k < 8) begin
      m.stop();
      m.start();
      m.wbyte(8'h6A, ack);
      k++;
    end
    ak(1'b1);
    m.stop();
  endtask

  task automatic rrd(input logic [15:0] wa, input logic [7:0] e [3], input int n);
    addr(wa);
    m.start();
    m.wbyte(8'h6B, ack);
    ak(1'b1);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i < n - 1, d);
      chk(d, e[i]);
    end
    m.stop();
  endtask

  initial begin
    sys_rst = 1'b1;
    write_protect = 1'b0;
    device_select_pins = 3'h5;
    fail_count = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
    bad(8'hBA);
    bad(8'h68);
    addr(16'h003E);
    for (int i = 0; i < 4; i++) begin
      m.wbyte(8'hA0 + 8'(i), ack);
      ak(1'b1);
    end
    m.stop();
    finish_write();
    addr(16'h7FFF);
    for (int i = 0; i < 66; i++) begin
      m.wbyte(8'(i), ack);
      ak(1'b1);
    end
    m.stop();
    finish_write();
    write_protect <= 1'b1;
    addr(16'h003E);
    m.wbyte(8'h55, ack);
    ak(1'b0);
    m.stop();
    repeat (10) @(posedge clk);
    chk({7'h00, write_busy}, 8'h00);
    write_protect <= 1'b0;
    rrd(16'hFFFF, '{8'h40, 8'hA2, 8'hA3}, 3);
    rrd(16'h7FC0, '{8'h41, 8'h02, 8'h00}, 2);
    rrd(16'h003E, '{8'hA0, 8'h00, 8'h00}, 1);
    m.start();
    m.wbyte(8'h6B, ack);
    ak(1'b1);
    m.rbyte(1'b0, d);
    chk(d, 8'hA1);
    m.stop();
    results();
  end

  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    results();
  end
endmodule
